// ===== logic/pmaf_alert_flags.v
// Purpose: diagnostic flags, limit compare and alert for a power monitor
// Assumes: measurement core presents results with raw and averaged strobes
// Notes:   register port is the internal side of the serial interface
`timescale 1ns/1ps
`include "pmaf_defines.vh"

module pmaf_alert_flags
(
    // clock and reset
    input  wire                      i_clk,
    input  wire                      i_reset,
    // register port
    input  wire [`PMAF_ADDR_W-1:0]   i_reg_addr,
    input  wire                      i_reg_wr,
    input  wire                      i_reg_rd,
    input  wire [`PMAF_REG_W-1:0]    i_reg_wdata,
    output reg  [`PMAF_POWER_W-1:0]  o_reg_rdata,
    output reg                       o_reg_rvalid,
    // measurement core results
    input  wire                      i_raw_valid,
    input  wire                      i_avg_valid,
    input  wire [`PMAF_REG_W-1:0]    i_shunt_result,
    input  wire [`PMAF_BUS_W-1:0]    i_bus_result,
    input  wire [`PMAF_TEMP_W-1:0]   i_die_temperature_result,
    input  wire [`PMAF_POWER_W-1:0]  i_power_calc,
    // measurement core events
    input  wire                      i_conv_done,
    input  wire                      i_conv_start,
    input  wire                      i_math_overflow,
    input  wire                      i_trim_checksum_err,
    // limits held outside this block
    input  wire [`PMAF_REG_W-1:0]    i_shunt_under_limit,
    input  wire [`PMAF_BUS_W-1:0]    i_bus_over_limit,
    input  wire [`PMAF_BUS_W-1:0]    i_bus_under_limit,
    input  wire [`PMAF_TEMP_W-1:0]   i_temp_limit_field,
    input  wire [`PMAF_REG_W-1:0]    i_power_limit,
    // alert pin
    output wire                      o_alert_o,
    output wire                      o_alert_oe,
    // status
    output reg  [`PMAF_REG_W-1:0]    o_shunt_over_limit
);

    // ****************************************
    // configuration and flag registers
    // ****************************************
    reg                        alert_latch_select_q;
    reg                        ready_on_alert_enable_q;
    reg                        averaged_compare_select_q;
    reg                        alert_pin_polarity_q;
    reg                        math_overflow_flag_q;
    reg                        temp_over_flag_q;
    reg                        shunt_over_flag_q;
    reg                        shunt_under_flag_q;
    reg                        bus_over_flag_q;
    reg                        bus_under_flag_q;
    reg                        power_over_flag_q;
    reg                        conversion_done_flag_q;
    reg                        trim_checksum_ok_q;
    reg  [`PMAF_POWER_W-1:0]   power_result_q;

    // ****************************************
    // decode
    // ****************************************
    wire wr_diag;
    wire wr_shunt_over_limit;
    wire rd_diag;

    assign wr_diag = i_reg_wr && (i_reg_addr == `PMAF_OFS_DIAG);
    assign wr_shunt_over_limit = i_reg_wr && (i_reg_addr == `PMAF_OFS_SHUNT_OVER_LIMIT);
    assign rd_diag = i_reg_rd && (i_reg_addr == `PMAF_OFS_DIAG);

    // ****************************************
    // compares
    // ****************************************
    wire                     shunt_over;
    wire                     shunt_under;
    wire                     bus_over;
    wire                     bus_under;
    wire                     temp_over;
    wire                     power_over;
    wire [`PMAF_POWER_W-1:0] power_limit_x;
    wire                     cmp_strobe;

    // limit counts in steps of 256 power result units
    assign power_limit_x = {i_power_limit, {`PMAF_PLIM_SHIFT{1'b0}}};

    // averaged compare waits for the completed average; slower but quieter
    assign cmp_strobe = averaged_compare_select_q ? i_avg_valid : i_raw_valid;

    pmaf_limit_cmp #(.W(`PMAF_REG_W), .SIGNED(1)) u_shunt_cmp
    (
        .i_value (i_shunt_result),
        .i_upper (o_shunt_over_limit),
        .i_lower (i_shunt_under_limit),
        .o_over  (shunt_over),
        .o_under (shunt_under)
    );

    pmaf_limit_cmp #(.W(`PMAF_BUS_W), .SIGNED(0)) u_bus_cmp
    (
        .i_value (i_bus_result),
        .i_upper (i_bus_over_limit),
        .i_lower (i_bus_under_limit),
        .o_over  (bus_over),
        .o_under (bus_under)
    );

    pmaf_limit_cmp #(.W(`PMAF_TEMP_W), .SIGNED(1)) u_temp_cmp
    (
        .i_value (i_die_temperature_result),
        .i_upper (i_temp_limit_field),
        .i_lower (i_die_temperature_result),
        .o_over  (temp_over),
        .o_under ()
    );

    pmaf_limit_cmp #(.W(`PMAF_POWER_W), .SIGNED(0)) u_power_cmp
    (
        .i_value (i_power_calc),
        .i_upper (power_limit_x),
        .i_lower (i_power_calc),
        .o_over  (power_over),
        .o_under ()
    );

    // ****************************************
    // flag update
    // ****************************************
    // latched: hold and or-in, read clears, a new fault in the read cycle wins
    // transparent: flag follows the latest compared result
    function flag_next;
        input cur;
        input cond;
        input strobe;
        input latched;
        input clr;
        begin
            if (latched)
                flag_next = (strobe & cond) | (cur & ~clr);
            else if (strobe)
                flag_next = cond;
            else
                flag_next = cur;
        end
    endfunction

    wire latch_clr;

    assign latch_clr = rd_diag;

    always @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            temp_over_flag_q   <= 1'b0;
            shunt_over_flag_q  <= 1'b0;
            shunt_under_flag_q <= 1'b0;
            bus_over_flag_q    <= 1'b0;
            bus_under_flag_q   <= 1'b0;
            power_over_flag_q  <= 1'b0;
        end
        else
        begin
            temp_over_flag_q   <= flag_next(temp_over_flag_q, temp_over, cmp_strobe,
                                            alert_latch_select_q, latch_clr);
            shunt_over_flag_q  <= flag_next(shunt_over_flag_q, shunt_over, cmp_strobe,
                                            alert_latch_select_q, latch_clr);
            shunt_under_flag_q <= flag_next(shunt_under_flag_q, shunt_under, cmp_strobe,
                                            alert_latch_select_q, latch_clr);
            bus_over_flag_q    <= flag_next(bus_over_flag_q, bus_over, cmp_strobe,
                                            alert_latch_select_q, latch_clr);
            bus_under_flag_q   <= flag_next(bus_under_flag_q, bus_under, cmp_strobe,
                                            alert_latch_select_q, latch_clr);
            power_over_flag_q  <= flag_next(power_over_flag_q, power_over, cmp_strobe,
                                            alert_latch_select_q, latch_clr);
        end
    end

    // ****************************************
    // status flags
    // ****************************************
    always @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            math_overflow_flag_q   <= 1'b0;
            conversion_done_flag_q <= 1'b0;
            trim_checksum_ok_q     <= `PMAF_TRIM_OK_RESET;
        end
        else
        begin
            // set wins over the clear of a starting conversion
            if (i_math_overflow)
                math_overflow_flag_q <= 1'b1;
            else if (i_conv_start)
                math_overflow_flag_q <= 1'b0;
            if (i_conv_done)
                conversion_done_flag_q <= 1'b1;
            else if (i_conv_start || (alert_latch_select_q && rd_diag))
                conversion_done_flag_q <= 1'b0;
            // once bad the trim stays flagged until reset
            if (i_trim_checksum_err)
                trim_checksum_ok_q <= 1'b0;
        end
    end

    // ****************************************
    // configuration writes
    // ****************************************
    always @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            alert_latch_select_q      <= 1'b0;
            ready_on_alert_enable_q   <= 1'b0;
            averaged_compare_select_q <= 1'b0;
            alert_pin_polarity_q      <= 1'b0;
            o_shunt_over_limit        <= `PMAF_SHUNT_OVER_LIMIT_RESET;
        end
        else
        begin
            if (wr_diag)
            begin
                alert_latch_select_q      <= i_reg_wdata[`PMAF_B_LATCH];
                ready_on_alert_enable_q   <= i_reg_wdata[`PMAF_B_RDY_ALERT];
                averaged_compare_select_q <= i_reg_wdata[`PMAF_B_AVG_CMP];
                alert_pin_polarity_q      <= i_reg_wdata[`PMAF_B_POLARITY];
            end
            if (wr_shunt_over_limit)
                o_shunt_over_limit <= i_reg_wdata;
        end
    end

    // ****************************************
    // power result
    // ****************************************
    // the core raises the averaged strobe only once the whole average is done
    always @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
            power_result_q <= `PMAF_POWER_RESET;
        else if (i_avg_valid)
            power_result_q <= i_power_calc;
    end

    // ****************************************
    // read path
    // ****************************************
    reg [`PMAF_REG_W-1:0] diag_word;

    always @*
    begin
        diag_word                      = {`PMAF_REG_W{1'b0}};
        diag_word[`PMAF_B_LATCH]       = alert_latch_select_q;
        diag_word[`PMAF_B_RDY_ALERT]   = ready_on_alert_enable_q;
        diag_word[`PMAF_B_AVG_CMP]     = averaged_compare_select_q;
        diag_word[`PMAF_B_POLARITY]    = alert_pin_polarity_q;
        diag_word[`PMAF_B_MATH_OF]     = math_overflow_flag_q;
        diag_word[`PMAF_B_TEMP_OVER]   = temp_over_flag_q;
        diag_word[`PMAF_B_SHUNT_OVER]  = shunt_over_flag_q;
        diag_word[`PMAF_B_SHUNT_UNDER] = shunt_under_flag_q;
        diag_word[`PMAF_B_BUS_OVER]    = bus_over_flag_q;
        diag_word[`PMAF_B_BUS_UNDER]   = bus_under_flag_q;
        diag_word[`PMAF_B_POWER_OVER]  = power_over_flag_q;
        diag_word[`PMAF_B_CONV_DONE]   = conversion_done_flag_q;
        diag_word[`PMAF_B_TRIM_OK]     = trim_checksum_ok_q;
    end

    always @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            o_reg_rdata  <= {`PMAF_POWER_W{1'b0}};
            o_reg_rvalid <= 1'b0;
        end
        else
        begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd)
            begin
                case (i_reg_addr)
                    `PMAF_OFS_DIAG:  o_reg_rdata <= {{`PMAF_POWER_W-`PMAF_REG_W{1'b0}}, diag_word};
                    `PMAF_OFS_SHUNT_OVER_LIMIT:  o_reg_rdata <= {{`PMAF_POWER_W-`PMAF_REG_W{1'b0}},
                                                     o_shunt_over_limit};
                    `PMAF_OFS_POWER: o_reg_rdata <= power_result_q;
                    default:         o_reg_rdata <= {`PMAF_POWER_W{1'b0}};
                endcase
            end
        end
    end

    // ****************************************
    // alert
    // ****************************************
    wire alert_active;

    assign alert_active = temp_over_flag_q | shunt_over_flag_q | shunt_under_flag_q
                        | bus_over_flag_q | bus_under_flag_q | power_over_flag_q
                        | (ready_on_alert_enable_q & conversion_done_flag_q);

    pmaf_alert_pin u_alert_pin
    (
        .i_clk      (i_clk),
        .i_reset    (i_reset),
        .i_active   (alert_active),
        .i_polarity (alert_pin_polarity_q),
        .o_alert_o  (o_alert_o),
        .o_alert_oe (o_alert_oe)
    );

endmodule // pmaf_alert_flags

// ===== logic/pmaf_alert_pin.v
// Purpose: drive the open-drain alert pin with selectable polarity
// Assumes: external pull-up on the alert wire
// Notes:   the pin is only ever pulled low, never driven high
`timescale 1ns/1ps

module pmaf_alert_pin
(
    // clock and reset
    input  wire i_clk,
    input  wire i_reset,
    // control
    input  wire i_active,
    input  wire i_polarity,
    // pin
    output reg  o_alert_o,
    output reg  o_alert_oe
);

    // ****************************************
    // pin drive
    // ****************************************
    // active high open-drain means release when active, pull low when idle
    always @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            o_alert_o  <= 1'b0;
            o_alert_oe <= 1'b0;
        end
        else
        begin
            o_alert_o  <= 1'b0;
            o_alert_oe <= i_polarity ? ~i_active : i_active;
        end
    end

endmodule // pmaf_alert_pin

// ===== logic/pmaf_defines.vh
// Purpose: constants for the power monitor alert flag block
// Assumes: 16-bit register words, 24-bit power result
// Notes:   register offsets are word addresses of the register port
`ifndef PMAF_DEFINES_VH
`define PMAF_DEFINES_VH

// ****************************************
// register offsets
// ****************************************
`define PMAF_ADDR_W          6
`define PMAF_OFS_POWER       6'h08
`define PMAF_OFS_DIAG        6'h0b
`define PMAF_OFS_SHUNT_OVER_LIMIT        6'h0c

// ****************************************
// reset values
// ****************************************
`define PMAF_DIAG_RESET      16'h0001
`define PMAF_SHUNT_OVER_LIMIT_RESET      16'h7fff
`define PMAF_POWER_RESET     24'h000000
`define PMAF_TRIM_OK_RESET   1'b1

// ****************************************
// diagnostic register fields
// ****************************************
`define PMAF_B_LATCH         15
`define PMAF_B_RDY_ALERT     14
`define PMAF_B_AVG_CMP       13
`define PMAF_B_POLARITY      12
`define PMAF_B_MATH_OF       9
`define PMAF_B_TEMP_OVER     7
`define PMAF_B_SHUNT_OVER    6
`define PMAF_B_SHUNT_UNDER   5
`define PMAF_B_BUS_OVER      4
`define PMAF_B_BUS_UNDER     3
`define PMAF_B_POWER_OVER    2
`define PMAF_B_CONV_DONE     1
`define PMAF_B_TRIM_OK       0

// ****************************************
// widths
// ****************************************
`define PMAF_REG_W           16
`define PMAF_POWER_W         24
`define PMAF_TEMP_W          12
`define PMAF_BUS_W           15
`define PMAF_PLIM_SHIFT      8

`endif

// ===== logic/pmaf_limit_cmp.v
// Purpose: compare one result against one upper and one lower limit
// Assumes: both limits share the result's width and sign
// Notes:   purely combinational
`timescale 1ns/1ps

module pmaf_limit_cmp
#(
    parameter W      = 16,
    parameter SIGNED = 1
)
(
    // operands
    input  wire [W-1:0] i_value,
    input  wire [W-1:0] i_upper,
    input  wire [W-1:0] i_lower,
    // results
    output wire         o_over,
    output wire         o_under
);

    // ****************************************
    // compare
    // ****************************************
    // flipping the sign bit turns a signed compare into an unsigned one
    wire [W-1:0] val_x;
    wire [W-1:0] upr_x;
    wire [W-1:0] lwr_x;

    assign val_x   = SIGNED ? {~i_value[W-1], i_value[W-2:0]} : i_value;
    assign upr_x   = SIGNED ? {~i_upper[W-1], i_upper[W-2:0]} : i_upper;
    assign lwr_x   = SIGNED ? {~i_lower[W-1], i_lower[W-2:0]} : i_lower;
    assign o_over  = (val_x > upr_x);
    assign o_under = (val_x < lwr_x);

endmodule // pmaf_limit_cmp

// ===== verification/pmaf_alert_flags_assertions.sv
// Purpose: port-level checks of the alert flag block
// Assumes: single clock domain, async reset
// Notes:   config bits shadowed from register writes
`timescale 1ns/1ps
`include "pmaf_defines.vh"

module pmaf_alert_flags_chk
(
    // clock and reset
    input wire                     i_clk,
    input wire                     i_reset,
    // register port
    input wire [`PMAF_ADDR_W-1:0]  i_reg_addr,
    input wire                     i_reg_wr,
    input wire                     i_reg_rd,
    input wire [`PMAF_REG_W-1:0]   i_reg_wdata,
    input wire [`PMAF_POWER_W-1:0] o_reg_rdata,
    // results and events
    input wire                     i_raw_valid,
    input wire                     i_avg_valid,
    input wire [`PMAF_REG_W-1:0]   i_shunt_result,
    input wire [`PMAF_POWER_W-1:0] i_power_calc,
    input wire                     i_conv_done,
    input wire                     i_conv_start,
    // alert and status
    input wire                     o_alert_o,
    input wire                     o_alert_oe,
    input wire [`PMAF_REG_W-1:0]   o_shunt_over_limit
);
    reg  [3:0]  cfg_q;
    reg  [23:0] pwr_q;
    reg         quiet_q;
    wire        diag_rd = i_reg_rd && i_reg_addr == `PMAF_OFS_DIAG;
    wire        diag_wr = i_reg_wr && i_reg_addr == `PMAF_OFS_DIAG;
    wire        quiet   = !diag_rd && !diag_wr && !i_conv_start;
    wire        act     = o_alert_oe != cfg_q[0];
    wire        mapped  = i_reg_addr == `PMAF_OFS_DIAG || i_reg_addr == `PMAF_OFS_SHUNT_OVER_LIMIT
                          || i_reg_addr == `PMAF_OFS_POWER;

    // ****************************************
    // shadow state
    // ****************************************
    always @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            cfg_q   <= 4'h0;
            pwr_q   <= 24'h000000;
            quiet_q <= 1'b0;
        end
        else
        begin
            if (diag_wr)
                cfg_q <= i_reg_wdata[15:12];
            if (i_avg_valid)
                pwr_q <= i_power_calc;
            quiet_q <= quiet;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    a_rsvd_zero: assert property (diag_rd |=> o_reg_rdata[23:16] == 8'h00
        && o_reg_rdata[11:10] == 2'h0 && !o_reg_rdata[8]) else $error("reserved bits set");
    a_unmapped_zero: assert property (i_reg_rd && !mapped |=> o_reg_rdata == 24'h0)
        else $error("unmapped read not zero");
    a_pin_never_high: assert property (o_alert_o == 1'b0)
        else $error("alert pin driven high");
    a_shunt_over_limit_reset: assert property ($fell(i_reset) |-> o_shunt_over_limit == 16'h7fff)
        else $error("shunt limit reset wrong");
    a_shunt_over_limit_write: assert property (i_reg_wr && i_reg_addr == `PMAF_OFS_SHUNT_OVER_LIMIT
        |=> o_shunt_over_limit == $past(i_reg_wdata)) else $error("shunt limit not stored");
    a_over_alert: assert property (i_raw_valid && !cfg_q[1]
        && $signed(i_shunt_result) > $signed(o_shunt_over_limit) |-> ##2 act)
        else $error("shunt over gave no alert");
    a_ready_alert: assert property (cfg_q[2] && i_conv_done |-> ##2 act)
        else $error("ready gave no alert");
    a_latched_hold: assert property (cfg_q[3] && act && quiet && quiet_q |=> act)
        else $error("latched alert dropped");
    a_power_read: assert property (i_reg_rd && i_reg_addr == `PMAF_OFS_POWER
        && !i_avg_valid |=> o_reg_rdata == $past(pwr_q)) else $error("power read wrong");

    c_latched_read: cover property (diag_rd && cfg_q[3] && act);
    c_avg_compare: cover property (i_avg_valid && cfg_q[1]);
    c_inverted_alert: cover property (cfg_q[0] && act);
endmodule // pmaf_alert_flags_chk

bind pmaf_alert_flags pmaf_alert_flags_chk u_pmaf_alert_flags_chk (.i_clk, .i_reset,
    .i_reg_addr, .i_reg_wr, .i_reg_rd, .i_reg_wdata, .o_reg_rdata, .i_raw_valid,
    .i_avg_valid, .i_shunt_result, .i_power_calc, .i_conv_done, .i_conv_start,
    .o_alert_o, .o_alert_oe, .o_shunt_over_limit);

// ===== verification/pmaf_alert_flags_tb.sv
// Purpose: register-level tests of the alert flag block
// Assumes: inputs change at the falling edge
// Notes:   alert seen through the pulled-up host wire
`timescale 1ns/1ps
`include "pmaf_defines.vh"

module pmaf_alert_flags_tb;
    localparam [5:0] DG = `PMAF_OFS_DIAG;
    localparam [5:0] SO = `PMAF_OFS_SHUNT_OVER_LIMIT;
    localparam [5:0] PW = `PMAF_OFS_POWER;
    reg         i_clk = 1'b0;
    reg         i_reset = 1'b1;
    reg  [5:0]  i_reg_addr = 6'h00;
    reg         i_reg_wr = 1'b0;
    reg         i_reg_rd = 1'b0;
    reg  [15:0] i_reg_wdata = 16'h0000;
    reg         i_raw_valid = 1'b0;
    reg         i_avg_valid = 1'b0;
    reg  [15:0] i_shunt_result = 16'h0000;
    reg  [14:0] i_bus_result = 15'h0080;
    reg  [11:0] i_die_temperature_result = 12'h050;
    reg  [23:0] i_power_calc = 24'h00ff00;
    reg         i_conv_done = 1'b0;
    reg         i_conv_start = 1'b0;
    reg         i_math_overflow = 1'b0;
    reg         i_trim_checksum_err = 1'b0;
    reg  [15:0] i_shunt_under_limit = 16'hff00;
    reg  [14:0] i_bus_over_limit = 15'h0100;
    reg  [14:0] i_bus_under_limit = 15'h0010;
    reg  [11:0] i_temp_limit_field = 12'h100;
    reg  [15:0] i_power_limit = 16'h0100;
    wire [23:0] o_reg_rdata;
    wire        o_reg_rvalid;
    wire        o_alert_o;
    wire        o_alert_oe;
    wire [15:0] o_shunt_over_limit;
    wire        alert_pin;
    integer     fails = 0;
    integer     total_checks = 0;
    integer     i;

    always #5 i_clk = ~i_clk;

    pmaf_alert_flags u_pmaf_alert_flags (.i_clk, .i_reset, .i_reg_addr, .i_reg_wr,
        .i_reg_rd, .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid, .i_raw_valid, .i_avg_valid,
        .i_shunt_result, .i_bus_result, .i_die_temperature_result, .i_power_calc,
        .i_conv_done, .i_conv_start, .i_math_overflow, .i_trim_checksum_err,
        .i_shunt_under_limit, .i_bus_over_limit, .i_bus_under_limit, .i_temp_limit_field,
        .i_power_limit, .o_alert_o, .o_alert_oe, .o_shunt_over_limit);
    pmaf_host_pin u_pmaf_host_pin (.i_alert_o(o_alert_o), .i_alert_oe(o_alert_oe),
        .o_alert_level(alert_pin));

    // ****************************************
    // tasks
    // ****************************************
    task chk(input [23:0] got, input [23:0] exp);
    begin
        total_checks = total_checks + 1;
        if (got !== exp)
        begin
            fails = fails + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask

    task end_sim;
    begin
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    end
    endtask

    task wr_reg(input [5:0] a, input [15:0] d);
    begin
        @(negedge i_clk);
        i_reg_addr = a;
        i_reg_wdata = d;
        i_reg_wr = 1'b1;
        @(negedge i_clk);
        i_reg_wr = 1'b0;
    end
    endtask

    task rd_reg(input [5:0] a, input [23:0] exp);
        integer n;
    begin
        n = 0;
        @(negedge i_clk);
        i_reg_addr = a;
        i_reg_rd = 1'b1;
        @(negedge i_clk);
        i_reg_rd = 1'b0;
        while (o_reg_rvalid !== 1'b1 && n < 4)
        begin
            @(negedge i_clk);
            n = n + 1;
        end
        chk(o_reg_rvalid, 24'h1);
        chk(o_reg_rdata, exp);
    end
    endtask

    // one result set under a raw or averaged strobe, then room for the alert
    task smp(input raw, input [15:0] sh, input [14:0] bu, input [11:0] tp, input [23:0] pw);
    begin
        @(negedge i_clk);
        {i_shunt_result, i_bus_result, i_die_temperature_result, i_power_calc} =
            {sh, bu, tp, pw};
        i_raw_valid = raw;
        i_avg_valid = !raw;
        @(negedge i_clk);
        i_raw_valid = 1'b0;
        i_avg_valid = 1'b0;
        repeat (2) @(negedge i_clk);
    end
    endtask

    task nom;
        smp(1'b1, 16'h0000, 15'h0080, 12'h050, 24'h00ff00);
    endtask

    // done, start, overflow, trim error
    task ev(input [3:0] m);
    begin
        @(negedge i_clk);
        {i_conv_done, i_conv_start, i_math_overflow, i_trim_checksum_err} = m;
        @(negedge i_clk);
        {i_conv_done, i_conv_start, i_math_overflow, i_trim_checksum_err} = 4'h0;
        repeat (2) @(negedge i_clk);
    end
    endtask

    // ****************************************
    // tests
    // ****************************************
    initial
    begin
        repeat (12) @(negedge i_clk);
        i_reset = 1'b0;
        rd_reg(DG, 24'h000001);
        rd_reg(SO, 24'h007fff);
        rd_reg(6'h20, 24'h000000);
        wr_reg(SO, 16'h0100);
        wr_reg(PW, 16'h1234);
        rd_reg(SO, 24'h000100);
        rd_reg(PW, 24'h000000);
        nom;
        chk(alert_pin, 24'h1);
        for (i = 0; i < 6; i = i + 1)
        begin
            case (i)
                0: smp(1'b1, 16'h0000, 15'h0080, 12'h101, 24'h00ff00);
                1: smp(1'b1, 16'h0101, 15'h0080, 12'h050, 24'h00ff00);
                2: smp(1'b1, 16'hfeff, 15'h0080, 12'h050, 24'h00ff00);
                3: smp(1'b1, 16'h0000, 15'h0101, 12'h050, 24'h00ff00);
                4: smp(1'b1, 16'h0000, 15'h000f, 12'h050, 24'h00ff00);
                default: smp(1'b1, 16'h0000, 15'h0080, 12'h050, 24'h010001);
            endcase
            rd_reg(DG, 24'h000001 | (24'h000080 >> i));
            chk(alert_pin, 24'h0);
            nom;
            rd_reg(DG, 24'h000001);
            chk(alert_pin, 24'h1);
        end
        wr_reg(SO, 16'hfff0);
        nom;
        rd_reg(DG, 24'h000041);
        wr_reg(SO, 16'h0100);
        nom;
        wr_reg(DG, 16'h2000);
        smp(1'b1, 16'h0200, 15'h0080, 12'h050, 24'h000123);
        rd_reg(DG, 24'h002001);
        rd_reg(PW, 24'h000000);
        smp(1'b0, 16'h0200, 15'h0080, 12'h050, 24'h000123);
        rd_reg(DG, 24'h002041);
        rd_reg(PW, 24'h000123);
        wr_reg(DG, 16'h8000);
        smp(1'b1, 16'h0200, 15'h0080, 12'h050, 24'h00ff00);
        nom;
        chk(alert_pin, 24'h0);
        rd_reg(DG, 24'h008041);
        rd_reg(DG, 24'h008001);
        chk(alert_pin, 24'h1);
        wr_reg(DG, 16'hc000);
        ev(4'h8);
        chk(alert_pin, 24'h0);
        rd_reg(DG, 24'h00c003);
        rd_reg(DG, 24'h00c001);
        ev(4'h8);
        ev(4'h4);
        rd_reg(DG, 24'h00c001);
        wr_reg(DG, 16'h0000);
        ev(4'h8);
        chk(alert_pin, 24'h1);
        rd_reg(DG, 24'h000003);
        ev(4'h4);
        rd_reg(DG, 24'h000001);
        ev(4'h2);
        rd_reg(DG, 24'h000201);
        rd_reg(DG, 24'h000201);
        ev(4'h4);
        rd_reg(DG, 24'h000001);
        wr_reg(DG, 16'h1000);
        repeat (3) @(negedge i_clk);
        chk(alert_pin, 24'h0);
        smp(1'b1, 16'h0200, 15'h0080, 12'h050, 24'h00ff00);
        chk(alert_pin, 24'h1);
        nom;
        ev(4'h1);
        rd_reg(DG, 24'h001000);
        end_sim;
    end

    // hang guard, far beyond the few hundred cycles the tests need
    initial
    begin
        #100000;
        fails = fails + 1;
        $display("wrong value at %0t: watchdog expired", $time);
        end_sim;
    end
endmodule // pmaf_alert_flags_tb

// ===== verification/pmaf_host_pin.sv
// Purpose: host side of the alert wire with its pull-up
// Assumes: one open-drain driver on the wire
// Notes:   a released wire reads high
`timescale 1ns/1ps

module pmaf_host_pin
(
    // from device
    input  wire i_alert_o,
    input  wire i_alert_oe,
    // seen by host
    output wire o_alert_level
);
    // pull-up wins whenever the driver lets go
    assign o_alert_level = i_alert_oe ? i_alert_o : 1'b1;
endmodule // pmaf_host_pin
